// ### design/pio_pkg.sv
// constants shared by the parallel port block: register indices, bit masks, reset values
package pio_pkg;

  // ****************************************************************
  // port numbering
  // ****************************************************************
  localparam int NPORT       = 5;          // ports a, b, c, d, f
  localparam int PORT_A      = 0;          // slot of port a
  localparam int PORT_B      = 1;          // slot of port b
  localparam int PORT_C      = 2;          // slot of port c
  localparam int PORT_D      = 3;          // slot of port d
  localparam int PORT_F      = 4;          // slot of port f
  localparam int ANALOG_PORT = PORT_B;     // port whose pins feed the converter
  localparam int PW          = 16;         // register and port width

  typedef logic [PW-1:0] pio_word_t;       // one port's worth of bits

  // ****************************************************************
  // register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [NPORT-1:0][15:0] DIR_IDX = {16'h02DE, 16'h02D2, 16'h02CC,
                                                16'h02C6, 16'h02C0};
  localparam logic [NPORT-1:0][15:0] PIN_IDX = {16'h02E0, 16'h02D4, 16'h02CE,
                                                16'h02C8, 16'h02C2};
  localparam logic [NPORT-1:0][15:0] LAT_IDX = {16'h02E2, 16'h02D6, 16'h02D0,
                                                16'h02CB, 16'h02C4};
  localparam logic [15:0]            ANSEL_IDX = 16'h02A8;  // analog pin select
  localparam int                     IDX_SHIFT = 2;         // index to byte address

  // ****************************************************************
  // implemented bits per variant; direction resets to these (inputs)
  // ****************************************************************
  localparam pio_word_t MASK_ABSENT  = 16'h0000;
  localparam pio_word_t MASK_A_LARGE = 16'hF6C0;
  localparam pio_word_t MASK_B       = 16'hFFFF;
  localparam pio_word_t MASK_C_LARGE = 16'hE01E;
  localparam pio_word_t MASK_C_SMALL = 16'hE006;
  localparam pio_word_t MASK_D_LARGE = 16'hFFFF;
  localparam pio_word_t MASK_D_SMALL = 16'h0FFF;
  localparam pio_word_t MASK_F       = 16'h007F;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam pio_word_t LAT_RST   = 16'h0000;  // output latch
  localparam pio_word_t PIN_RST   = 16'h0000;  // sampled pin level
  localparam pio_word_t ANSEL_RST = 16'h0000;  // every pin digital
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// ### design/pio_ports.sv
// parallel i/o ports a, b, c, d, f with analog pin selection, apb register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module pio_ports
  import pio_pkg::*;
#(
  parameter int LARGE_PKG = 1,   // 1 larger package map, 0 smaller
  parameter int APB_AW    = 12   // apb address width
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // port a pins
  input  wire logic [15:0]       pin_in_a,
  output logic      [15:0]       pin_out_a,
  output logic      [15:0]       pin_oe_n_a,
  // port b pins
  input  wire logic [15:0]       pin_in_b,
  output logic      [15:0]       pin_out_b,
  output logic      [15:0]       pin_oe_n_b,
  // port c pins
  input  wire logic [15:0]       pin_in_c,
  output logic      [15:0]       pin_out_c,
  output logic      [15:0]       pin_oe_n_c,
  // port d pins
  input  wire logic [15:0]       pin_in_d,
  output logic      [15:0]       pin_out_d,
  output logic      [15:0]       pin_oe_n_d,
  // port f pins
  input  wire logic [15:0]       pin_in_f,
  output logic      [15:0]       pin_out_f,
  output logic      [15:0]       pin_oe_n_f,
  // converter side, port b pins
  output logic      [15:0]       analog_route,
  output logic      [15:0]       analog_input_pin
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (LARGE_PKG != 0 && LARGE_PKG != 1) begin : g_bad_variant
    $error("pio_ports: LARGE_PKG must be 0 or 1");
  end
  if (APB_AW < 12 || APB_AW > 32) begin : g_bad_aw
    $error("pio_ports: APB_AW must lie between 12 and 32");
  end
  if (ANALOG_PORT >= NPORT) begin : g_bad_analog
    $error("pio_ports: ANALOG_PORT must name one of the ports");
  end

  // ****************************************************************
  // implemented bit masks for the chosen variant
  // ****************************************************************
  localparam bit LARGE = (LARGE_PKG == 1);
  // an absent port gets an all-zero mask, so it never drives nor decodes
  localparam logic [NPORT-1:0][15:0] MASK = {
    MASK_F,
    LARGE ? MASK_D_LARGE : MASK_D_SMALL,
    LARGE ? MASK_C_LARGE : MASK_C_SMALL,
    MASK_B,
    LARGE ? MASK_A_LARGE : MASK_ABSENT
  };

  // ****************************************************************
  // state
  // ****************************************************************
  logic [NPORT-1:0][15:0] dir_q,   dir_d;    // direction, 1 = input
  logic [NPORT-1:0][15:0] lat_q,   lat_d;    // output latches
  logic [NPORT-1:0][15:0] sync1_q, sync1_d;  // first synchroniser stage
  logic [NPORT-1:0][15:0] sync2_q, sync2_d;  // second synchroniser stage
  logic [NPORT-1:0][15:0] pin_in_all;        // pins gathered by slot
  logic [NPORT-1:0][15:0] pin_lvl;           // value the pin register reads
  pio_word_t              ansel_q, ansel_d;  // analog pin select, port b
  pio_word_t              an_chan;           // pins that are analog inputs
  logic [31:0]            prdata_q, prdata_d; // read data, loaded in setup
  logic                   err_q,   err_d;    // unmapped address seen in setup
  logic [31:0]            addr32;            // zero extended address
  logic                   wr_en;             // write access phase
  logic                   setup;             // setup phase

  assign pin_in_all = {pin_in_f, pin_in_d, pin_in_c, pin_in_b, pin_in_a};
  assign addr32     = 32'(paddr);
  assign wr_en      = psel & penable & pwrite;
  assign setup      = psel & ~penable;

  // byte address of a register index
  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    byte_addr = 32'(idx) << IDX_SHIFT;
  endfunction

  // ****************************************************************
  // analog selection
  // ****************************************************************
  // a pin is an analog input only when selected and set as input
  assign an_chan          = ansel_q & dir_q[ANALOG_PORT];
  // selected pins reach the converter whatever their direction, so an
  // output pin converts its own driven level; unselected pins never do
  assign analog_route     = ansel_q;
  assign analog_input_pin = an_chan;

  // ****************************************************************
  // per port pin view
  // ****************************************************************
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    if (p == ANALOG_PORT) begin : g_an
      // analog input channels read low, not the pin voltage
      assign pin_lvl[p] = sync2_q[p] & MASK[p] & ~an_chan;
    end else begin : g_dig
      assign pin_lvl[p] = sync2_q[p] & MASK[p];
    end
  end

  // pin drivers: unimplemented bits never drive
  // a pin drives its latch only while its direction bit is zero
  assign pin_out_a  = lat_q[PORT_A];
  assign pin_out_b  = lat_q[PORT_B];
  assign pin_out_c  = lat_q[PORT_C];
  assign pin_out_d  = lat_q[PORT_D];
  assign pin_out_f  = lat_q[PORT_F];
  assign pin_oe_n_a = dir_q[PORT_A] | ~MASK[PORT_A];
  assign pin_oe_n_b = dir_q[PORT_B] | ~MASK[PORT_B];
  assign pin_oe_n_c = dir_q[PORT_C] | ~MASK[PORT_C];
  assign pin_oe_n_d = dir_q[PORT_D] | ~MASK[PORT_D];
  assign pin_oe_n_f = dir_q[PORT_F] | ~MASK[PORT_F];

  // ****************************************************************
  // synchroniser
  // ****************************************************************
  // pins move at any time; the second stage gives a metastable first
  // stage a whole cycle to settle before the register read sees it
  // next values; stage one feeds stage two only
  always_comb begin
    sync1_d = pin_in_all;
    sync2_d = sync1_q;
  end

  // registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= {NPORT{PIN_RST}};
      sync2_q <= {NPORT{PIN_RST}};
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // next values; writes are masked so absent bits stay zero
  always_comb begin
    dir_d   = dir_q;
    lat_d   = lat_q;
    ansel_d = ansel_q;
    if (wr_en) begin
      // port indices are all distinct, so one branch hits at most
      for (int p = 0; p < NPORT; p++) begin
        if (addr32 == byte_addr(DIR_IDX[p])) begin
          dir_d[p] = pwdata[15:0] & MASK[p];
        end else if (addr32 == byte_addr(LAT_IDX[p])) begin
          lat_d[p] = pwdata[15:0] & MASK[p];
        end else if (addr32 == byte_addr(PIN_IDX[p])) begin
          // writing the pin register lands in the latch
          lat_d[p] = pwdata[15:0] & MASK[p];
        end
      end
      if (addr32 == byte_addr(ANSEL_IDX)) begin
        ansel_d = pwdata[15:0];
      end
    end
  end

  // registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_q   <= MASK;
      lat_q   <= {NPORT{LAT_RST}};
      ansel_q <= ANSEL_RST;
    end else begin
      dir_q   <= dir_d;
      lat_q   <= lat_d;
      ansel_q <= ansel_d;
    end
  end

  // ****************************************************************
  // read data and decode, captured in the setup phase
  // ****************************************************************
  // capturing in setup keeps prdata a flop while still answering with no
  // wait state; the pin view is thus one cycle older than the access edge
  always_comb begin
    prdata_d = prdata_q;
    err_d    = err_q;
    if (setup) begin
      // unmapped until a decode hit below clears the error
      prdata_d = RDATA_RST;
      err_d    = 1'b1;
      for (int p = 0; p < NPORT; p++) begin
        if (addr32 == byte_addr(DIR_IDX[p]) && MASK[p] != MASK_ABSENT) begin
          prdata_d = 32'(dir_q[p]);
          err_d    = 1'b0;
        end else if (addr32 == byte_addr(LAT_IDX[p]) && MASK[p] != MASK_ABSENT) begin
          prdata_d = 32'(lat_q[p]);
          err_d    = 1'b0;
        end else if (addr32 == byte_addr(PIN_IDX[p]) && MASK[p] != MASK_ABSENT) begin
          prdata_d = 32'(pin_lvl[p]);
          err_d    = 1'b0;
        end
      end
      if (addr32 == byte_addr(ANSEL_IDX)) begin
        prdata_d = 32'(ansel_q);
        err_d    = 1'b0;
      end
      // a write answers zero rather than a stale register
      if (pwrite) begin
        prdata_d = RDATA_RST;
      end
    end
  end

  // registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= RDATA_RST;
      err_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  // zero wait states: every access phase lasts exactly one cycle
  assign prdata  = prdata_q;
  assign pready  = 1'b1;                       // never waits
  assign pslverr = psel & penable & err_q;     // absent port a maps to error too

  // ****************************************************************
  // assertions
  // ****************************************************************
  // every check samples on the rising edge; all but a_reset_values rest while in reset
  logic rd_acc;   // read access phase
  assign rd_acc = psel & penable & ~pwrite;

  a_analog_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_acc && addr32 == byte_addr(PIN_IDX[ANALOG_PORT]) && $stable(an_chan)
    |-> (prdata[15:0] & an_chan) == 16'h0000)
    else $error("analog input pin read back non-zero");

  a_analog_drives_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ((ansel_q & ~dir_q[ANALOG_PORT]) & pin_oe_n_b) == 16'h0000)
    else $error("analog selected output pin not driven");

  a_digital_unrouted: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (analog_route & ~ansel_q) == 16'h0000 &&
    (analog_input_pin & ~ansel_q) == 16'h0000)
    else $error("digital pin routed to converter");

  a_dir_write_oe: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && addr32 == byte_addr(DIR_IDX[PORT_C])
    |=> pin_oe_n_c == ($past(pwdata[15:0]) | ~MASK[PORT_C]))
    else $error("direction write did not reach port c drivers");

  a_lat_write_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && addr32 == byte_addr(LAT_IDX[PORT_D])
    |=> pin_out_d == ($past(pwdata[15:0]) & MASK[PORT_D]))
    else $error("latch write did not reach port d outputs");

  a_pin_write_lat: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && addr32 == byte_addr(PIN_IDX[PORT_F])
    |=> pin_out_f == ($past(pwdata[15:0]) & MASK[PORT_F]))
    else $error("pin register write did not reach port f latch");

  a_unimpl_read_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_acc && !err_q |-> (prdata[31:16] == 16'h0000) &&
    (addr32 != byte_addr(LAT_IDX[PORT_C]) || (prdata[15:0] & ~MASK[PORT_C]) == 16'h0000))
    else $error("unimplemented bits read non-zero");

  a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_acc && addr32 == byte_addr(PIN_IDX[PORT_D]) && $past(setup)
    |-> prdata[15:0] == ($past(pin_in_d, 3) & MASK[PORT_D]))
    else $error("port d pin read not three cycles behind pins");

  a_reset_values: assert property (@(posedge sys_clk)
    $fell(sys_rst) |-> pin_oe_n_a == 16'hFFFF && pin_oe_n_b == 16'hFFFF &&
    pin_oe_n_c == 16'hFFFF && pin_oe_n_d == 16'hFFFF && pin_oe_n_f == 16'hFFFF &&
    pin_out_b == LAT_RST && pin_out_d == LAT_RST && dir_q == MASK)
    else $error("wrong state after reset");

  a_port_a_absent: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !LARGE |-> pin_oe_n_a == 16'hFFFF && pin_out_a == 16'h0000)
    else $error("absent port a is active");

  // a refused write, unmapped or to an absent port, leaves every register alone
  a_unmapped_write_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && err_q |=> $stable(dir_q) && $stable(lat_q) && $stable(ansel_q))
    else $error("refused write changed a register");

  // a refused read answers zero so no stale data leaks onto the bus
  a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_acc && err_q |-> prdata == RDATA_RST)
    else $error("refused read returned data");

  // a select write reaches the converter routing one cycle later
  a_select_write_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && addr32 == byte_addr(ANSEL_IDX)
    |=> analog_route == $past(pwdata[15:0]))
    else $error("analog select write did not reach the router");

  // an analog input pin never has its driver on
  a_analog_not_driven: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (analog_input_pin & ~pin_oe_n_b) == 16'h0000)
    else $error("analog input pin is driven");

  // read data stands from one setup phase to the next
  a_read_data_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !setup |=> $stable(prdata))
    else $error("read data changed outside a setup phase");

  // per port: absent bits stay zero and register reads return the flops
  for (genvar p = 0; p < NPORT; p++) begin : g_chk
    // direction and latch keep zeros where no pin exists
    a_absent_bits_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ((dir_q[p] | lat_q[p]) & ~MASK[p]) == 16'h0000)
      else $error("unimplemented bit holds a one");

    // direction reads back as written, absent bits as zero
    a_dir_reads_back: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_acc && !err_q && addr32 == byte_addr(DIR_IDX[p]) |-> prdata[15:0] == dir_q[p])
      else $error("direction register read back wrong");

    // the latch register reads the latch itself, not the pins
    a_lat_reads_back: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rd_acc && !err_q && addr32 == byte_addr(LAT_IDX[p]) |-> prdata[15:0] == lat_q[p])
      else $error("latch register read back wrong");
  end

  // ****************************************************************
  // cover points for the main scenarios
  // ****************************************************************

  c_analog_read: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_acc && addr32 == byte_addr(PIN_IDX[ANALOG_PORT]) && an_chan != 16'h0000);
  c_dir_then_lat: cover property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en && addr32 == byte_addr(DIR_IDX[PORT_B]) ##[1:20]
    wr_en && addr32 == byte_addr(LAT_IDX[PORT_B]));
  c_unmapped: cover property (@(posedge sys_clk) disable iff (sys_rst) pslverr);
  c_pin_read_d: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_acc && addr32 == byte_addr(PIN_IDX[PORT_D]));
  c_analog_output: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (ansel_q & ~dir_q[ANALOG_PORT]) != 16'h0000);

endmodule

// ### dv/pio_pin_model.sv
// external pin model: resolves every pad from device drive and far-side drive
`timescale 1ns/1ns
// ****************************************************************
// pin model
// ****************************************************************
module pio_pin_model #(
  parameter int W = 80                      // pads of all five ports
) (
  input  wire logic         sys_clk,        // pattern clock for floating pads
  input  wire logic [W-1:0] pin_out,        // device drive value
  input  wire logic [W-1:0] pin_oe_n,       // device enable, low drives
  input  wire logic [W-1:0] ext_val,        // far-side drive value
  input  wire logic [W-1:0] ext_en,         // far-side enable, high drives
  output logic      [W-1:0] pin_in          // resolved pad level
);
  logic float_q = 1'b0;                     // toggles so a released pad never looks stable

  // released pads show a changing pattern, not a remembered value
  always @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  // device drive wins while its enable is low, over any far-side drive the bench applies
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = float_q;
      end
    end
  end
endmodule

// ### dv/pio_ports_test.sv
// self-checking bench for the parallel port block, both package variants
`timescale 1ns/1ns
module pio_ports_test;
  import pio_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        sys_clk = 1'b0;              // 10 MHz
  logic        sys_rst = 1'b1;              // async, active high
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, prdata2;             // large and small variant read data
  logic        pready, pready2, pslverr, pslverr2;
  logic [79:0] pout, poe, pin, ext_val, ext_en;
  logic [15:0] aroute, ain;                 // converter side of port b
  logic [31:0] rd, rd2;                     // last read data
  logic        err, err2;                   // last error flags
  int          n_errors = 0, n_compared = 0;
  localparam pio_word_t ML[5] = '{MASK_A_LARGE, MASK_B, MASK_C_LARGE, MASK_D_LARGE, MASK_F};
  localparam pio_word_t MS[5] = '{MASK_ABSENT, MASK_B, MASK_C_SMALL, MASK_D_SMALL, MASK_F};

  always #50 sys_clk = ~sys_clk;

  // ****************************************************************
  // instances; the small variant shares the bus and the pads
  // ****************************************************************
  pio_ports #(.LARGE_PKG(1), .APB_AW(12)) pio_ports_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in_a(pin[15:0]), .pin_out_a(pout[15:0]), .pin_oe_n_a(poe[15:0]),
    .pin_in_b(pin[31:16]), .pin_out_b(pout[31:16]), .pin_oe_n_b(poe[31:16]),
    .pin_in_c(pin[47:32]), .pin_out_c(pout[47:32]), .pin_oe_n_c(poe[47:32]),
    .pin_in_d(pin[63:48]), .pin_out_d(pout[63:48]), .pin_oe_n_d(poe[63:48]),
    .pin_in_f(pin[79:64]), .pin_out_f(pout[79:64]), .pin_oe_n_f(poe[79:64]),
    .analog_route(aroute), .analog_input_pin(ain));
  pio_ports #(.LARGE_PKG(0), .APB_AW(12)) pio_ports_small_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(pready2), .pslverr(pslverr2),
    .pin_in_a(pin[15:0]), .pin_out_a(), .pin_oe_n_a(), .pin_in_b(pin[31:16]), .pin_out_b(),
    .pin_oe_n_b(), .pin_in_c(pin[47:32]), .pin_out_c(), .pin_oe_n_c(), .pin_in_d(pin[63:48]),
    .pin_out_d(), .pin_oe_n_d(), .pin_in_f(pin[79:64]), .pin_out_f(), .pin_oe_n_f(),
    .analog_route(), .analog_input_pin());
  pio_pin_model #(.W(80)) pio_pin_model_inst (.sys_clk(sys_clk), .pin_out(pout),
    .pin_oe_n(poe), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [11:0] ba(input logic [15:0] idx);
    return 12'(idx << IDX_SHIFT);           // index to byte address
  endfunction

  // one apb transfer; junk in the upper write half must be ignored
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {16'hFFFF, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata; rd2 = prdata2; err = pslverr; err2 = pslverr2;
    psel <= 1'b0; penable <= 1'b0;
    // let a write land in the flops before any scenario looks at the pins
    @(negedge sys_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int p = 0; p < 5; p++) begin
      chk(32'(pout[p*16 +: 16]), 32'h0, "pins low");
      chk(32'(poe[p*16 +: 16]), 32'h0000_FFFF, "pins released");
      apb(1'b0, ba(DIR_IDX[p]), 16'h0000);
      chk(rd, {16'h0000, ML[p]}, "dir large");
      chk(rd2, {16'h0000, MS[p]}, "dir small");
      if (p == PORT_A) chk(32'(err2), 32'h1, "small a absent");
      apb(1'b0, ba(LAT_IDX[p]), 16'h0000);
      chk(rd, 32'h0, "lat rst");
      apb(1'b0, ba(PIN_IDX[p]), 16'h0000);
      chk(rd, 32'h0, "pin rst");
    end
    $display("test reset done");
  endtask

  task automatic t_latch();
    for (int p = 0; p < 5; p++) begin
      apb(1'b1, ba(LAT_IDX[p]), 16'hFFFF);
      apb(1'b0, ba(LAT_IDX[p]), 16'h0000);
      chk(rd, {16'h0000, ML[p]}, "lat mask");
      chk(32'(pout[p*16 +: 16]), 32'(ML[p]), "pin out");
      apb(1'b1, ba(PIN_IDX[p]), 16'h5A5A);
      apb(1'b0, ba(LAT_IDX[p]), 16'h0000);
      chk(rd, {16'h0000, 16'h5A5A & ML[p]}, "pin write");
      apb(1'b1, ba(DIR_IDX[p]), 16'h0000);
      chk(32'(poe[p*16 +: 16]), {16'h0000, ~ML[p]}, "drive on");
      apb(1'b1, ba(DIR_IDX[p]), 16'hFFFF);
      apb(1'b0, ba(DIR_IDX[p]), 16'h0000);
      chk(rd, {16'h0000, ML[p]}, "dir back");
    end
    $display("test latch done");
  endtask

  task automatic t_pins();
    @(posedge sys_clk);
    ext_val <= {5{16'hA5A5}};
    repeat (3) @(posedge sys_clk);
    for (int p = 0; p < 5; p++) begin
      apb(1'b0, ba(PIN_IDX[p]), 16'h0000);
      chk(rd, {16'h0000, 16'hA5A5 & ML[p]}, "pin in");
    end
    @(posedge sys_clk);
    ext_val <= {5{16'h3C3C}};
    apb(1'b0, ba(PIN_IDX[PORT_B]), 16'h0000);
    chk(rd, 32'h0000_A5A5, "sync old");
    apb(1'b0, ba(PIN_IDX[PORT_B]), 16'h0000);
    chk(rd, 32'h0000_3C3C, "sync new");
    apb(1'b1, ba(LAT_IDX[PORT_C]), 16'h0006);
    apb(1'b1, ba(DIR_IDX[PORT_C]), 16'h0000);
    repeat (3) @(posedge sys_clk);
    apb(1'b0, ba(PIN_IDX[PORT_C]), 16'h0000);
    chk(rd, 32'h0000_0006, "own drive");
    apb(1'b1, ba(DIR_IDX[PORT_C]), 16'hFFFF);
    $display("test pins done");
  endtask

  task automatic t_analog();
    apb(1'b1, ba(LAT_IDX[PORT_B]), 16'h0005);
    apb(1'b1, ba(DIR_IDX[PORT_B]), 16'hFFFF);
    apb(1'b1, ba(ANSEL_IDX), 16'h00FF);
    @(posedge sys_clk);
    ext_val[31:16] <= 16'hFFFF;
    chk(32'(aroute), 32'h0000_00FF, "route");
    chk(32'(ain), 32'h0000_00FF, "analog in");
    repeat (3) @(posedge sys_clk);
    apb(1'b0, ba(PIN_IDX[PORT_B]), 16'h0000);
    chk(rd, 32'h0000_FF00, "analog zero");
    apb(1'b1, ba(DIR_IDX[PORT_B]), 16'hFFF0);
    chk(32'(ain), 32'h0000_00F0, "out not in");
    chk(32'(aroute), 32'h0000_00FF, "out converts");
    chk(32'(poe[31:16]), 32'h0000_FFF0, "still drives");
    repeat (3) @(posedge sys_clk);
    apb(1'b0, ba(PIN_IDX[PORT_B]), 16'h0000);
    chk(rd, 32'h0000_FF05, "mixed read");
    apb(1'b1, ba(ANSEL_IDX), 16'h0000);
    chk(32'(aroute), 32'h0, "digital only");
    $display("test analog done");
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'hFFC, 16'h1234);
    chk(32'(err), 32'h1, "wr unmapped");
    apb(1'b0, 12'hFFC, 16'h0000);
    chk(32'(err), 32'h1, "rd unmapped");
    chk(rd, 32'h0, "rd zero");
    $display("test unmapped done");
  endtask

  // ****************************************************************
  // verdict, watchdog, main sequence
  // ****************************************************************
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the tests need well under 2000 cycles
  initial begin
    #500000;
    n_errors++;
    test_done();
  end

  initial begin
    ext_val = 80'h0;
    ext_en = {80{1'b1}};
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_latch();
    t_pins();
    t_analog();
    t_unmapped();
    test_done();
  end
endmodule
